// [hw/adcsq_consts.svh]
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH
// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define ADCSQ_IDX_CTL0    8'h1F
`define ADCSQ_IDX_CTL1    8'h9F
`define ADCSQ_IDX_CTL2    8'h20
`define ADCSQ_IDX_RES_HI  8'h21
`define ADCSQ_IDX_RES_LO  8'h22
`define ADCSQ_IDX_INT_ST  8'h23
`define ADCSQ_IDX_INT_MSK 8'h24
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define ADCSQ_C0_CLK_HI   7
`define ADCSQ_C0_CLK_LO   6
`define ADCSQ_C0_CH_LSB   3
`define ADCSQ_C0_GO       2
`define ADCSQ_C0_CH_TOP   1
`define ADCSQ_C0_PWR      0
`define ADCSQ_C1_JUST     7
`define ADCSQ_C1_HALVE    6
`define ADCSQ_C1_NEG      5
`define ADCSQ_C1_POS      4
`define ADCSQ_C2_ACQ_LSB  3
`define ADCSQ_C2_WMASK    8'h38
`define ADCSQ_CTL_RST     8'h00
`define ADCSQ_INT_DONE    0
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADCSQ_SYS_CLK_NS  50
`define ADCSQ_RC_TAD_NS   4000
`define ADCSQ_RC_TAD_CYC  ((`ADCSQ_RC_TAD_NS) / (`ADCSQ_SYS_CLK_NS))
`define ADCSQ_TCY_NS      200
`define ADCSQ_TCY_CYC     ((`ADCSQ_TCY_NS) / (`ADCSQ_SYS_CLK_NS))
`define ADCSQ_HOLD_TADS   2
`define ADCSQ_SETTLE_CYC  3'h4
`define ADCSQ_NUM_CH      14
`endif

// [hw/adcsq_conv_if.sv]
`timescale 1ns/1ps
`default_nettype none
// signals between sequencer, conversion clock and approximation engine
interface adcsq_conv_if;
  logic       tad;         // one-cycle conversion-bit enable
  logic       tad_run;     // divider running
  logic [2:0] div_sel;     // {halve, hi, lo} clock source code
  logic       sar_start;   // begin a conversion
  logic       sar_run;     // held high while converting, low aborts
  logic       sar_done;    // one-cycle end of conversion
  logic [9:0] sar_code;    // trial code, final result at done
  logic       cmp_level;   // filtered comparator level
  modport ctl (output tad_run, div_sel, sar_start, sar_run, cmp_level,
               input tad, sar_done, sar_code);
  modport tdg (input tad_run, div_sel, output tad);
  modport sar (input tad, sar_start, sar_run, cmp_level,
               output sar_done, sar_code);
endinterface
`default_nettype wire

// [hw/adcsq_pkg.sv]
`default_nettype none
package adcsq_pkg;
  // sequencer states
  typedef enum logic [2:0] {SQ_IDLE, SQ_ACQ, SQ_RCW, SQ_CONV, SQ_HOLD} adcsq_seq_t;
  // approximation engine states
  typedef enum logic [1:0] {SA_IDLE, SA_SETUP, SA_BITS, SA_FIN} adcsq_sar_st_t;
  // top module state
  typedef struct packed {
    logic [2:0]  cmp_s;
    logic        cmp_st;
    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [7:0]  ctl2;
    logic [9:0]  result;
    logic        int_st;
    logic        int_msk;
    adcsq_seq_t  state;
    logic [4:0]  cnt;
    logic        sar_start;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } adcsq_top_st_t;
  // approximation engine state
  typedef struct packed {
    adcsq_sar_st_t st;
    logic [9:0]    code;
    logic [3:0]    bitn;
    logic [2:0]    settle;
    logic          done;
  } adcsq_sar_s_t;
  // conversion clock divider state
  typedef struct packed {
    logic [7:0] cnt;
    logic       tad;
  } adcsq_tad_s_t;
endpackage
`default_nettype wire

// [hw/adcsq_sar.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_consts.svh"
// successive approximation engine, one setup, ten bits, one finish
module adcsq_sar (
  input  wire logic  sys_clk,  // system clock
  input  wire logic  rst_b,    // synchronised reset, active low
  adcsq_conv_if.sar  cif       // engine controls
);
  adcsq_pkg::adcsq_sar_s_t q_ff, nxt_q;
  logic [9:0] kept;            // trial code after comparator decision

  // ----------------------------------------------------------------
  // engine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    kept = cif.cmp_level ? q_ff.code : (q_ff.code & ~(10'h001 << q_ff.bitn));
    if (q_ff.settle != 3'h0) begin
      nxt_q.settle = q_ff.settle - 3'h1;
    end
    if (!cif.sar_run) begin
      // abort or power off
      nxt_q.st = adcsq_pkg::SA_IDLE;
    end else begin
      case (q_ff.st)
        adcsq_pkg::SA_IDLE: begin
          if (cif.sar_start) nxt_q.st = adcsq_pkg::SA_SETUP;
        end
        adcsq_pkg::SA_SETUP: begin
          if (cif.tad) begin
            nxt_q.code   = 10'h200;
            nxt_q.bitn   = 4'h9;
            nxt_q.settle = `ADCSQ_SETTLE_CYC;
            nxt_q.st     = adcsq_pkg::SA_BITS;
          end
        end
        adcsq_pkg::SA_BITS: begin
          if (cif.tad && q_ff.settle == 3'h0) begin
            if (q_ff.bitn == 4'h0) begin
              nxt_q.code = kept;
              nxt_q.st   = adcsq_pkg::SA_FIN;
            end else begin
              nxt_q.code   = kept | (10'h001 << (q_ff.bitn - 4'h1));
              nxt_q.bitn   = q_ff.bitn - 4'h1;
              nxt_q.settle = `ADCSQ_SETTLE_CYC;
            end
          end
        end
        default: begin
          if (cif.tad) begin
            nxt_q.done = 1'b1;
            nxt_q.st   = adcsq_pkg::SA_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign cif.sar_done = q_ff.done;
  assign cif.sar_code = q_ff.code;
endmodule
`default_nettype wire

// [hw/adcsq_tad_gen.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_consts.svh"
// conversion clock: one-cycle enable every selected period
module adcsq_tad_gen #(
  parameter logic [7:0] RC_DIV = 8'(`ADCSQ_RC_TAD_CYC)  // internal rc period in cycles
) (
  input  wire logic  sys_clk,  // system clock
  input  wire logic  rst_b,    // synchronised reset, active low
  adcsq_conv_if.tdg  cif       // divider controls
);
  adcsq_pkg::adcsq_tad_s_t q_ff, nxt_q;

  // terminal count for each clock source code
  function automatic logic [7:0] last_cnt(input logic [2:0] s);
    logic [7:0] r;
    r = 8'h00;
    case (s)
      3'h0: r = 8'h01;           // 2 periods
      3'h4: r = 8'h03;           // 4 periods
      3'h1: r = 8'h07;           // 8 periods
      3'h5: r = 8'h0F;           // 16 periods
      3'h2: r = 8'h1F;           // 32 periods
      3'h6: r = 8'h3F;           // 64 periods
      default: r = RC_DIV - 8'h01; // internal rc clock
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.tad = 1'b0;
    if (!cif.tad_run) begin
      nxt_q.cnt = 8'h00;
    end else if (q_ff.cnt >= last_cnt(cif.div_sel)) begin
      nxt_q.cnt = 8'h00;
      nxt_q.tad = 1'b1;
    end else begin
      nxt_q.cnt = q_ff.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign cif.tad = q_ff.tad;
endmodule
`default_nettype wire

// [hw/adcsq_top.sv]
// Summary of operation
// - converts selected input to ten-bit result
// - start bit runs acquisition then conversion
// - channel and start accepted in one write
// - fourteen or eleven channels, rest unimplemented
// - channel code from bits 5-3 and 1
// - two result bytes, three control registers
// - control zero: clock, channel, start, power
// - control one: justify, halve, references, ports
// - positive reference: supply or external pin
// - port code turns high channels digital
// - control two holds acquisition time
// - done: load result, clear start, flag
// - acquisition 0,2,4,6,8,12,16,20 bit periods
// - clock: oscillator divided or internal rc
// - conversion lasts at least twelve periods
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_consts.svh"
module adcsq_top #(
  parameter int NUM_CH = `ADCSQ_NUM_CH  // implemented channels, 14 or 11
) (
  input  wire logic              sys_clk,          // 20 MHz system clock
  input  wire logic              rst_b,            // async reset, active low
  input  wire logic [11:0]       s_axi_awaddr,     // write address
  input  wire logic              s_axi_awvalid,    // write address valid
  output logic                   s_axi_awready,    // write address ready
  input  wire logic [31:0]       s_axi_wdata,      // write data
  input  wire logic [3:0]        s_axi_wstrb,      // write byte enables
  input  wire logic              s_axi_wvalid,     // write data valid
  output logic                   s_axi_wready,     // write data ready
  output logic [1:0]             s_axi_bresp,      // write response
  output logic                   s_axi_bvalid,     // write response valid
  input  wire logic              s_axi_bready,     // write response ready
  input  wire logic [11:0]       s_axi_araddr,     // read address
  input  wire logic              s_axi_arvalid,    // read address valid
  output logic                   s_axi_arready,    // read address ready
  output logic [31:0]            s_axi_rdata,      // read data
  output logic [1:0]             s_axi_rresp,      // read response
  output logic                   s_axi_rvalid,     // read data valid
  input  wire logic              s_axi_rready,     // read data ready
  input  wire logic              cmp_in,           // comparator: input above trial
  output logic                   converter_power_on, // analog power enable
  output logic [3:0]             chan_sel,         // selected channel
  output logic                   sample_en,        // sampling switch closed
  output logic [9:0]             dac_code,         // trial code to the dac
  output logic                   pos_ref_ext,      // upper reference from pin
  output logic                   neg_ref_ext,      // lower reference from pin
  output logic [NUM_CH-1:0]      analog_pin_mask,  // high = pin is analog
  output logic                   irq               // level interrupt
);
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  adcsq_pkg::adcsq_top_st_t q_ff, nxt_q;
  logic [1:0] rst_sync_ff;    // reset release synchroniser
  logic       rst_sync_b;     // synchronised reset
  adcsq_conv_if cif ();       // link to divider and engine
  logic       wr_take;        // write address and data taken
  logic       rd_take;        // read address taken
  logic [8:0] wr_dec;         // {hit, index} of write
  logic [8:0] rd_dec;         // {hit, index} of read
  logic       go_set_wr;      // software sets start this cycle
  logic       pwr;            // power bit after this cycle's write
  logic       go;             // start bit after this cycle's write
  logic [3:0] ch_code;        // channel code
  logic       ch_ok;          // channel implemented and analog
  logic [NUM_CH-1:0] amask;   // analog pins

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte address to {hit, index}, aligned words only
  function automatic logic [8:0] reg_dec(input logic [11:0] a);
    return {(a[11:10] == 2'h0) && (a[1:0] == 2'h0), a[9:2]};
  endfunction

  // bit periods for each acquisition code
  function automatic logic [4:0] acq_tads(input logic [2:0] c);
    logic [4:0] r;
    r = 5'h00;
    case (c)
      3'h1: r = 5'h02;
      3'h2: r = 5'h04;
      3'h3: r = 5'h06;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0C;
      3'h6: r = 5'h10;
      3'h7: r = 5'h14;
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // analog mask from port code, first NUM_CH of the 14 columns
  function automatic logic [NUM_CH-1:0] port_mask(input logic [3:0] p);
    logic [NUM_CH-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      m[i] = (p < 4'h2) || (i < (`ADCSQ_NUM_CH + 1 - int'(p)));
    end
    return m;
  endfunction

  // result byte in chosen justification
  function automatic logic [7:0] res_byte(input logic [9:0] r, input logic rj,
                                          input logic hi);
    logic [7:0] b;
    b = 8'h00;
    if (rj) begin
      b = hi ? {6'h00, r[9:8]} : r[7:0];
    end else begin
      b = hi ? r[9:2] : {r[1:0], 6'h00};
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // two flops so every flop leaves reset on the same edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // combinational decode and derived levels
  // ----------------------------------------------------------------
  assign wr_take   = s_axi_awvalid && s_axi_wvalid && !q_ff.bvalid;
  assign rd_take   = s_axi_arvalid && !q_ff.rvalid;
  assign wr_dec    = reg_dec(s_axi_awaddr);
  assign rd_dec    = reg_dec(s_axi_araddr);
  assign go_set_wr = wr_take && s_axi_wstrb[0] && wr_dec[8]
                     && (wr_dec[7:0] == `ADCSQ_IDX_CTL0)
                     && s_axi_wdata[`ADCSQ_C0_GO];
  assign ch_code = {q_ff.ctl0[`ADCSQ_C0_CH_TOP], q_ff.ctl0[`ADCSQ_C0_CH_LSB +: 3]};
  assign amask   = port_mask(q_ff.ctl1[3:0]);
  assign ch_ok   = (int'(ch_code) < NUM_CH) && amask[ch_code];

  // ----------------------------------------------------------------
  // registers, bus and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.sar_start = 1'b0;
    // three-flop comparator input, change once stages agree
    nxt_q.cmp_s = {q_ff.cmp_s[1:0], cmp_in};
    if (q_ff.cmp_s[1] == q_ff.cmp_s[2]) nxt_q.cmp_st = q_ff.cmp_s[2];

    // write channel
    if (q_ff.bvalid && s_axi_bready) nxt_q.bvalid = 1'b0;
    if (wr_take) begin
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp  = RESP_OK;
      if (!wr_dec[8]) begin
        nxt_q.bresp = RESP_ERR;
      end else if (wr_dec[7:0] == `ADCSQ_IDX_CTL0) begin
        if (s_axi_wstrb[0]) nxt_q.ctl0 = s_axi_wdata[7:0];
      end else if (wr_dec[7:0] == `ADCSQ_IDX_CTL1) begin
        if (s_axi_wstrb[0]) nxt_q.ctl1 = s_axi_wdata[7:0];
      end else if (wr_dec[7:0] == `ADCSQ_IDX_CTL2) begin
        if (s_axi_wstrb[0]) nxt_q.ctl2 = s_axi_wdata[7:0] & `ADCSQ_C2_WMASK;
      end else if (wr_dec[7:0] == `ADCSQ_IDX_INT_ST) begin
        // write one clears
        if (s_axi_wstrb[0] && s_axi_wdata[`ADCSQ_INT_DONE]) nxt_q.int_st = 1'b0;
      end else if (wr_dec[7:0] == `ADCSQ_IDX_INT_MSK) begin
        if (s_axi_wstrb[0]) nxt_q.int_msk = s_axi_wdata[`ADCSQ_INT_DONE];
      end else if (wr_dec[7:0] == `ADCSQ_IDX_RES_HI ||
                   wr_dec[7:0] == `ADCSQ_IDX_RES_LO) begin
        nxt_q.bresp = RESP_OK;    // read-only, write ignored
      end else begin
        nxt_q.bresp = RESP_ERR;   // unmapped
      end
    end

    // read channel
    if (q_ff.rvalid && s_axi_rready) nxt_q.rvalid = 1'b0;
    if (rd_take) begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rresp  = RESP_OK;
      nxt_q.rdata  = 32'h0000_0000;
      if (!rd_dec[8]) begin
        nxt_q.rresp = RESP_ERR;
      end else if (rd_dec[7:0] == `ADCSQ_IDX_CTL0) begin
        nxt_q.rdata[7:0] = q_ff.ctl0;
      end else if (rd_dec[7:0] == `ADCSQ_IDX_CTL1) begin
        nxt_q.rdata[7:0] = q_ff.ctl1;
      end else if (rd_dec[7:0] == `ADCSQ_IDX_CTL2) begin
        nxt_q.rdata[7:0] = q_ff.ctl2;
      end else if (rd_dec[7:0] == `ADCSQ_IDX_RES_HI) begin
        nxt_q.rdata[7:0] = res_byte(q_ff.result, q_ff.ctl1[`ADCSQ_C1_JUST], 1'b1);
      end else if (rd_dec[7:0] == `ADCSQ_IDX_RES_LO) begin
        nxt_q.rdata[7:0] = res_byte(q_ff.result, q_ff.ctl1[`ADCSQ_C1_JUST], 1'b0);
      end else if (rd_dec[7:0] == `ADCSQ_IDX_INT_ST) begin
        nxt_q.rdata[0] = q_ff.int_st;
      end else if (rd_dec[7:0] == `ADCSQ_IDX_INT_MSK) begin
        nxt_q.rdata[0] = q_ff.int_msk;
      end else begin
        nxt_q.rresp = RESP_ERR;
      end
    end

    // sequencer sees this cycle's write
    pwr = nxt_q.ctl0[`ADCSQ_C0_PWR];
    go  = nxt_q.ctl0[`ADCSQ_C0_GO];
    if (!pwr) begin
      nxt_q.ctl0[`ADCSQ_C0_GO] = 1'b0;
      nxt_q.state = adcsq_pkg::SQ_IDLE;
    end else begin
      case (q_ff.state)
        adcsq_pkg::SQ_IDLE: begin
          if (go) begin
            nxt_q.cnt = acq_tads(nxt_q.ctl2[`ADCSQ_C2_ACQ_LSB +: 3]);
            if (nxt_q.cnt != 5'h00) begin
              nxt_q.state = adcsq_pkg::SQ_ACQ;
            end else if (nxt_q.ctl0[`ADCSQ_C0_CLK_HI] && nxt_q.ctl0[`ADCSQ_C0_CLK_LO]) begin
              // rc clock waits one instruction cycle
              nxt_q.cnt   = 5'(`ADCSQ_TCY_CYC);
              nxt_q.state = adcsq_pkg::SQ_RCW;
            end else begin
              nxt_q.sar_start = 1'b1;
              nxt_q.state     = adcsq_pkg::SQ_CONV;
            end
          end
        end
        adcsq_pkg::SQ_ACQ: begin
          if (!go) begin
            nxt_q.state = adcsq_pkg::SQ_IDLE;
          end else if (cif.tad) begin
            nxt_q.cnt = q_ff.cnt - 5'h01;
            if (q_ff.cnt == 5'h01) begin
              nxt_q.sar_start = 1'b1;
              nxt_q.state     = adcsq_pkg::SQ_CONV;
            end
          end
        end
        adcsq_pkg::SQ_RCW: begin
          if (!go) begin
            nxt_q.state = adcsq_pkg::SQ_IDLE;
          end else begin
            nxt_q.cnt = q_ff.cnt - 5'h01;
            if (q_ff.cnt == 5'h01) begin
              nxt_q.sar_start = 1'b1;
              nxt_q.state     = adcsq_pkg::SQ_CONV;
            end
          end
        end
        adcsq_pkg::SQ_CONV: begin
          if (!go) begin
            nxt_q.state = adcsq_pkg::SQ_IDLE;
          end else if (cif.sar_done) begin
            nxt_q.result = cif.sar_code;
            if (!go_set_wr) nxt_q.ctl0[`ADCSQ_C0_GO] = 1'b0;
            nxt_q.int_st = 1'b1;
            nxt_q.cnt    = 5'(`ADCSQ_HOLD_TADS);
            nxt_q.state  = adcsq_pkg::SQ_HOLD;
          end
        end
        default: begin
          // gap before sampling resumes
          if (cif.tad) begin
            nxt_q.cnt = q_ff.cnt - 5'h01;
            if (q_ff.cnt == 5'h01) nxt_q.state = adcsq_pkg::SQ_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      q_ff       <= '0;
      q_ff.ctl0  <= `ADCSQ_CTL_RST;
      q_ff.ctl1  <= `ADCSQ_CTL_RST;
      q_ff.ctl2  <= `ADCSQ_CTL_RST;
      q_ff.state <= adcsq_pkg::SQ_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // conversion clock and engine
  // ----------------------------------------------------------------
  // clock source code
  assign cif.div_sel   = {q_ff.ctl1[`ADCSQ_C1_HALVE], q_ff.ctl0[`ADCSQ_C0_CLK_HI],
                          q_ff.ctl0[`ADCSQ_C0_CLK_LO]};
  assign cif.tad_run   = q_ff.ctl0[`ADCSQ_C0_PWR] && (q_ff.state != adcsq_pkg::SQ_IDLE)
                         && (q_ff.state != adcsq_pkg::SQ_RCW);
  assign cif.sar_start = q_ff.sar_start;
  assign cif.sar_run   = q_ff.state == adcsq_pkg::SQ_CONV;
  assign cif.cmp_level = q_ff.cmp_st;

  adcsq_tad_gen u_tad (
    .sys_clk (sys_clk),
    .rst_b   (rst_sync_b),
    .cif     (cif)
  );

  adcsq_sar u_sar (
    .sys_clk (sys_clk),
    .rst_b   (rst_sync_b),
    .cif     (cif)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready      = wr_take;
  assign s_axi_wready       = wr_take;
  assign s_axi_bvalid       = q_ff.bvalid;
  assign s_axi_bresp        = q_ff.bresp;
  assign s_axi_arready      = rd_take;
  assign s_axi_rvalid       = q_ff.rvalid;
  assign s_axi_rresp        = q_ff.rresp;
  assign s_axi_rdata        = q_ff.rdata;
  assign converter_power_on = q_ff.ctl0[`ADCSQ_C0_PWR];
  assign chan_sel           = ch_code;
  // sampling in idle and acquisition, off while converting
  assign sample_en          = converter_power_on && ch_ok &&
                              (q_ff.state == adcsq_pkg::SQ_IDLE ||
                               q_ff.state == adcsq_pkg::SQ_ACQ);
  assign dac_code           = cif.sar_code;
  assign pos_ref_ext        = q_ff.ctl1[`ADCSQ_C1_POS];
  assign neg_ref_ext        = q_ff.ctl1[`ADCSQ_C1_NEG];
  assign analog_pin_mask    = amask;
  assign irq                = q_ff.int_st && q_ff.int_msk;
endmodule
`default_nettype wire

// [testbench/adcsq_cmp_model.sv]
`timescale 1ns/1ps
`default_nettype none
// comparator and sampled input of the analog side
module adcsq_cmp_model (
  input wire logic       sys_clk,  // clock
  input wire logic       powered,  // converter powered
  input wire logic [9:0] dac_code, // trial code
  input wire logic [9:0] vin,      // sampled level
  output logic           cmp_in    // comparator out
);
  logic tgl = 1'b0; // junk level when unpowered
  always @(posedge sys_clk) tgl <= ~tgl;
  assign cmp_in = powered ? (vin >= dac_code) : tgl;
endmodule
`default_nettype wire

// [testbench/adcsq_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_properties #(
  parameter int NUM_CH = 14  // channels
) (
  input wire logic              sys_clk,            // clock
  input wire logic              rst_b,              // reset, active low
  input wire logic              s_axi_awvalid,      // aw valid
  input wire logic              s_axi_wvalid,       // w valid
  input wire logic              s_axi_awready,      // aw ready
  input wire logic              s_axi_wready,       // w ready
  input wire logic              s_axi_bvalid,       // b valid
  input wire logic              s_axi_bready,       // b ready
  input wire logic              s_axi_arvalid,      // ar valid
  input wire logic              s_axi_arready,      // ar ready
  input wire logic              s_axi_rvalid,       // r valid
  input wire logic              converter_power_on, // power
  input wire logic [3:0]        chan_sel,           // channel
  input wire logic              sample_en,          // sampling
  input wire logic [NUM_CH-1:0] analog_pin_mask     // analog pins
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write not answered");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  aw_gate_a: assert property (s_axi_awready |-> s_axi_wvalid && !s_axi_bvalid)
    else $error("write taken out of turn");
  w_pair_a: assert property (s_axi_wready == s_axi_awready)
    else $error("write data taken apart from address");
  pwr_off_a: assert property (!converter_power_on |-> !sample_en)
    else $error("sampling while unpowered");
  unimpl_ch_a: assert property (chan_sel >= NUM_CH |-> !sample_en)
    else $error("sampling absent channel");
  digital_pin_a: assert property (chan_sel < NUM_CH && !analog_pin_mask[chan_sel] |-> !sample_en)
    else $error("sampling digital pin");
  mask_shape_a: assert property ((analog_pin_mask & (analog_pin_mask + 1'b1)) == '0)
    else $error("analog pins not contiguous");
endmodule
bind adcsq_top adcsq_top_properties #(.NUM_CH(NUM_CH)) u_props (.*);
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, cmp_in, converter_power_on, sample_en;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic pos_ref_ext, neg_ref_ext;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, chan_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  dac_code, vin = 0;
  logic [13:0] analog_pin_mask;
  logic [33:0] q[$];  // expected bus answers
  int error_cnt = 0, checks_done = 0, n, ch, dv, aq;
  int acq_t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  initial forever #25 sys_clk = ~sys_clk;
  adcsq_top #(.NUM_CH(14)) DUT (.*);
  adcsq_cmp_model u_cmp (.sys_clk(sys_clk), .powered(converter_power_on),
    .dac_code(dac_code), .vin(vin), .cmp_in(cmp_in));
  task automatic chk(input string nm, input [33:0] s, e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one bus transfer, answer noted in the queue
  task automatic xfer(input bit w, input [9:0] a, input [31:0] d, input [33:0] e);
    q.push_back(e);
    if (w) begin
      s_axi_awaddr <= {a, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
    end else begin
      s_axi_araddr <= {a, 2'h0};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
    end
    do @(negedge sys_clk); while (!(w ? s_axi_awready : s_axi_arready));
    @(posedge sys_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    do @(negedge sys_clk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
    @(posedge sys_clk);
  endtask
  // monitor takes the oldest note per answer
  always @(negedge sys_clk)
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
      chk("bus", s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, q.pop_front());
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    complete_run;
  end
  initial begin
    n = $urandom(32'h96BD);
    repeat (3) @(posedge sys_clk);
    rst_b <= 1;
    repeat (3) @(posedge sys_clk);
    chk("mask", analog_pin_mask, 14'h3FFF);
    xfer(0, 10'h01F, 0, 0);
    xfer(0, 10'h09F, 0, 0);
    xfer(0, 10'h030, 0, 34'h200000000);
    xfer(1, 10'h030, 0, 34'h200000000);
    xfer(1, 10'h01F, 32'h04, 0);
    xfer(0, 10'h01F, 0, 0);
    xfer(1, 10'h01F, 32'h33, 0);
    chk("chan", {chan_sel, sample_en}, 5'h1C);
    xfer(1, 10'h01F, 32'h01, 0);
    for (int c = 0; c < 16; c++) begin
      n = $urandom % 4;
      xfer(1, 10'h09F, {n[1:0], c[3:0]}, 0);
      chk("cfg", {neg_ref_ext, pos_ref_ext, analog_pin_mask}, {n[1:0], c < 2 ? 14'h3FFF : 14'((15'h1 << (15 - c)) - 1)});
    end
    xfer(1, 10'h024, 1, 0);
    for (int k = 0; k < 8; k++) begin
      vin <= 10'($urandom);
      ch = $urandom % 14;
      dv = k[1:0] == 3 ? 80 : 2 << (2 * k[1:0] + k[2]);
      aq = acq_t[k ^ 3];
      xfer(1, 10'h09F, {k[0], k[2], 6'h0}, 0);
      xfer(1, 10'h020, (k ^ 3) << 3, 0);
      xfer(1, 10'h01F, {k[1:0], ch[2:0], 1'b1, ch[3], 1'b1}, 0);
      @(negedge sys_clk);
      chk("acq", {chan_sel, sample_en}, {ch[3:0], aq != 0});
      n = 4;
      while (!irq && n < 4000) begin
        @(negedge sys_clk);
        n++;
      end
      chk("time", n >= (11 + aq) * dv && n <= (16 + aq) * dv + 60, 1);
      @(posedge sys_clk);
      xfer(0, 10'h021, 0, k[0] ? vin[9:8] : vin[9:2]);
      xfer(0, 10'h022, 0, k[0] ? vin[7:0] : {vin[1:0], 6'h0});
      xfer(0, 10'h01F, 0, {k[1:0], ch[2:0], 1'b0, ch[3], 1'b1});
      xfer(1, 10'h024, 0, 0);
      chk("irqm", irq, 0);
      xfer(1, 10'h024, 1, 0);
      xfer(1, 10'h023, 1, 0);
      chk("irqc", irq, 0);
      repeat (200) @(posedge sys_clk);
    end
    complete_run;
  end
endmodule
`default_nettype wire
